// ---- smcd_consts.svh ----
// Constants for the sector map configuration detection table builder
`ifndef SMCD_CONSTS_SVH
`define SMCD_CONSTS_SVH

// ----------------------------------------------------------------------
// Table geometry
// ----------------------------------------------------------------------
`define SMCD_WORD_W        32
`define SMCD_ADDR_W        8
`define SMCD_TBL_DEPTH     9'h100
`define SMCD_CMD_ROOM      9'h0FE
`define SMCD_MAX_CMDS      4'h8
`define SMCD_LAST_CMD      4'h7

// ----------------------------------------------------------------------
// Descriptor fields
// ----------------------------------------------------------------------
`define SMCD_RSVD_HI_CMD   2'h3
`define SMCD_RSVD_LO       6'h3F
`define SMCD_RSVD_HDR      8'hFF
`define SMCD_TYPE_CMD      1'b0
`define SMCD_TYPE_MAP      1'b1
`define SMCD_F_MASK        31:24
`define SMCD_F_ALEN        23:22
`define SMCD_F_RSVD_HI     21:20
`define SMCD_F_LAT         19:16
`define SMCD_F_OPC         15:8
`define SMCD_F_RSVD_LO     7:2
`define SMCD_F_TYPE        1
`define SMCD_F_END         0
`define SMCD_F_HDR_RSVD    31:24
`define SMCD_F_RCNT        23:16
`define SMCD_F_CFG_ID      15:8
`define SMCD_HDR_EXTRA     10'h002
`define SMCD_UNMAPPED      32'hFFFF_FFFF

// ----------------------------------------------------------------------
// Reject causes
// ----------------------------------------------------------------------
`define SMCD_ERR_NONE      3'h0
`define SMCD_ERR_MASK      3'h1
`define SMCD_ERR_ORDER     3'h2
`define SMCD_ERR_LIMIT     3'h3
`define SMCD_ERR_SPACE     3'h4
`define SMCD_ERR_REGION    3'h5
`define SMCD_ERR_DONE      3'h6

`endif

// ---- smcd_host_model.sv ----
// Host side reader model that fetches one table word per request
`timescale 1ns/1ns

module smcd_host_model
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Bench command
    input  wire logic        go,
    input  wire logic [7:0]  idx,
    output logic      [31:0] word,
    output logic             got,
    // Table read port
    output logic             rd_req,
    output logic      [7:0]  rd_index,
    input  wire logic        rd_valid,
    input  wire logic [31:0] rd_data
);
    // Idle index keeps toggling so a stale index is never mistaken for a request
    always_ff @(posedge ref_clk or negedge resetn)
        if (!resetn)
        begin
            rd_req   <= 1'b0;
            rd_index <= 8'h00;
            word     <= 32'h0000_0000;
            got      <= 1'b0;
        end
        else
        begin
            rd_req   <= go;
            rd_index <= go ? idx : ~rd_index;
            got      <= rd_valid;
            if (rd_valid)
                word <= rd_data;
        end
endmodule

// ---- smcd_pkg.sv ----
// Types shared by the sector map table builder
package smcd_pkg;

    typedef enum logic [1:0]
    {
        SMCD_ST_OPEN = 2'b00,
        SMCD_ST_CMD2 = 2'b01,
        SMCD_ST_DONE = 2'b10
    } smcd_state_t;

    typedef enum logic [1:0]
    {
        SMCD_ENT_CMD    = 2'b00,
        SMCD_ENT_HDR    = 2'b01,
        SMCD_ENT_REGION = 2'b10
    } smcd_kind_t;

endpackage

// ---- smcd_table.sv ----
// Builder and reader of the sector map configuration detection table
`timescale 1ns/1ns
`include "smcd_consts.svh"

module smcd_table
    import smcd_pkg::*;
(
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    // Table control
    input  wire logic                      tbl_clear,
    // Entry intake
    input  wire logic                      ent_valid,
    input  wire smcd_kind_t                ent_kind,
    input  wire logic                      ent_last,
    input  wire logic [7:0]                ent_mask,
    input  wire logic [1:0]                ent_addr_len,
    input  wire logic [3:0]                ent_latency,
    input  wire logic [7:0]                ent_opcode,
    input  wire logic [31:0]               ent_addr,
    input  wire logic [7:0]                ent_cfg_id,
    input  wire logic [7:0]                ent_region_cnt,
    input  wire logic [31:0]               ent_region,
    output logic                           ent_ready,
    output logic                           ent_ack,
    output logic                           ent_err,
    output logic      [2:0]                err_cause,
    // Table status
    output logic                           tbl_done,
    output logic      [8:0]                tbl_len,
    output logic      [3:0]                cmd_count,
    output logic      [7:0]                map_count,
    // Table read port
    input  wire logic                      rd_req,
    input  wire logic [`SMCD_ADDR_W-1:0]   rd_index,
    output logic                           rd_valid,
    output logic      [`SMCD_WORD_W-1:0]   rd_data
);

    function automatic logic smcd_is_onehot(input logic [7:0] v);
        return (v != 8'h00) && ((v & (v - 8'h01)) == 8'h00);
    endfunction

    // ------------------------------------------------------------------
    // Builder state
    // ------------------------------------------------------------------
    smcd_state_t                state;
    smcd_state_t                next_state;
    logic [8:0]                 next_tbl_len;
    logic [3:0]                 next_cmd_count;
    logic [7:0]                 next_map_count;
    logic                       cmds_closed;
    logic                       next_cmds_closed;
    logic                       maps_started;
    logic                       next_maps_started;
    logic                       maps_closing;
    logic                       next_maps_closing;
    logic [8:0]                 regions_left;
    logic [8:0]                 next_regions_left;
    logic [31:0]                pend_addr;
    logic [31:0]                next_pend_addr;
    logic                       next_ent_ready;
    logic                       next_ent_ack;
    logic                       next_ent_err;
    logic [2:0]                 next_err_cause;
    logic                       next_tbl_done;
    logic                       mem_we;
    logic [`SMCD_WORD_W-1:0]    mem_wdata;
    logic [`SMCD_WORD_W-1:0]    mem_rdata;
    logic [2:0]                 cause;
    logic [9:0]                 hdr_need;
    logic                       take;

    assign hdr_need = {1'b0, tbl_len} + {2'b00, ent_region_cnt} + `SMCD_HDR_EXTRA;
    assign take     = ent_valid && ent_ready;

    always_comb
    begin
        next_state        = state;
        next_tbl_len      = tbl_len;
        next_cmd_count    = cmd_count;
        next_map_count    = map_count;
        next_cmds_closed  = cmds_closed;
        next_maps_started = maps_started;
        next_maps_closing = maps_closing;
        next_regions_left = regions_left;
        next_pend_addr    = pend_addr;
        next_ent_ack      = 1'b0;
        next_ent_err      = 1'b0;
        next_err_cause    = err_cause;
        next_tbl_done     = tbl_done;
        mem_we            = 1'b0;
        mem_wdata         = `SMCD_UNMAPPED;
        cause             = `SMCD_ERR_NONE;
        if (tbl_clear)
        begin
            next_state        = SMCD_ST_OPEN;
            next_tbl_len      = 9'h000;
            next_cmd_count    = 4'h0;
            next_map_count    = 8'h00;
            next_cmds_closed  = 1'b0;
            next_maps_started = 1'b0;
            next_maps_closing = 1'b0;
            next_regions_left = 9'h000;
            next_err_cause    = `SMCD_ERR_NONE;
            next_tbl_done     = 1'b0;
        end
        else
        begin
            case (state)
                SMCD_ST_OPEN:
                begin
                    if (take)
                    begin
                        case (ent_kind)
                            SMCD_ENT_CMD:
                            begin
                                if (maps_started || cmds_closed)
                                    cause = `SMCD_ERR_ORDER;
                                else if (!smcd_is_onehot(ent_mask))
                                    cause = `SMCD_ERR_MASK;
                                else if (cmd_count == `SMCD_LAST_CMD && !ent_last)
                                    cause = `SMCD_ERR_LIMIT;
                                else if (tbl_len > `SMCD_CMD_ROOM)
                                    cause = `SMCD_ERR_SPACE;
                                if (cause == `SMCD_ERR_NONE)
                                begin
                                    mem_we = 1'b1;
                                    mem_wdata[`SMCD_F_MASK]    = ent_mask;
                                    mem_wdata[`SMCD_F_ALEN]    = ent_addr_len;
                                    mem_wdata[`SMCD_F_RSVD_HI] = `SMCD_RSVD_HI_CMD;
                                    mem_wdata[`SMCD_F_LAT]     = ent_latency;
                                    mem_wdata[`SMCD_F_OPC]     = ent_opcode;
                                    mem_wdata[`SMCD_F_RSVD_LO] = `SMCD_RSVD_LO;
                                    mem_wdata[`SMCD_F_TYPE]    = `SMCD_TYPE_CMD;
                                    mem_wdata[`SMCD_F_END]     = ent_last;
                                    next_tbl_len     = tbl_len + 9'h001;
                                    next_pend_addr   = ent_addr;
                                    next_cmd_count   = cmd_count + 4'h1;
                                    next_cmds_closed = ent_last;
                                    next_state       = SMCD_ST_CMD2;
                                end
                            end
                            SMCD_ENT_HDR:
                            begin
                                // A header may not cut short the previous map
                                if (regions_left != 9'h000 || maps_closing ||
                                    (cmd_count != 4'h0 && !cmds_closed))
                                    cause = `SMCD_ERR_ORDER;
                                else if (hdr_need > {1'b0, `SMCD_TBL_DEPTH})
                                    cause = `SMCD_ERR_SPACE;
                                if (cause == `SMCD_ERR_NONE)
                                begin
                                    mem_we = 1'b1;
                                    mem_wdata[`SMCD_F_HDR_RSVD] = `SMCD_RSVD_HDR;
                                    mem_wdata[`SMCD_F_RCNT]     = ent_region_cnt;
                                    mem_wdata[`SMCD_F_CFG_ID]   = ent_cfg_id;
                                    mem_wdata[`SMCD_F_RSVD_LO]  = `SMCD_RSVD_LO;
                                    mem_wdata[`SMCD_F_TYPE]     = `SMCD_TYPE_MAP;
                                    mem_wdata[`SMCD_F_END]      = ent_last;
                                    next_tbl_len      = tbl_len + 9'h001;
                                    next_map_count    = map_count + 8'h01;
                                    next_maps_started = 1'b1;
                                    next_maps_closing = ent_last;
                                    next_regions_left = {1'b0, ent_region_cnt} + 9'h001;
                                end
                            end
                            SMCD_ENT_REGION:
                            begin
                                if (regions_left == 9'h000)
                                    cause = `SMCD_ERR_REGION;
                                if (cause == `SMCD_ERR_NONE)
                                begin
                                    mem_we            = 1'b1;
                                    mem_wdata         = ent_region;
                                    next_tbl_len      = tbl_len + 9'h001;
                                    next_regions_left = regions_left - 9'h001;
                                    if (regions_left == 9'h001 && maps_closing)
                                    begin
                                        next_state    = SMCD_ST_DONE;
                                        next_tbl_done = 1'b1;
                                    end
                                end
                            end
                            default:
                            begin
                                cause = `SMCD_ERR_REGION;
                            end
                        endcase
                        next_ent_ack   = (cause == `SMCD_ERR_NONE);
                        next_ent_err   = (cause != `SMCD_ERR_NONE);
                        next_err_cause = cause;
                    end
                end
                SMCD_ST_CMD2:
                begin
                    mem_we       = 1'b1;
                    mem_wdata    = pend_addr;
                    next_tbl_len = tbl_len + 9'h001;
                    next_state   = SMCD_ST_OPEN;
                end
                SMCD_ST_DONE:
                begin
                    if (take)
                    begin
                        next_ent_err   = 1'b1;
                        next_err_cause = `SMCD_ERR_DONE;
                    end
                end
                default:
                begin
                    next_state = SMCD_ST_OPEN;
                end
            endcase
        end
        // Intake stalls only while the address word is being stored
        next_ent_ready = (next_state != SMCD_ST_CMD2);
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state        <= SMCD_ST_OPEN;
            tbl_len      <= 9'h000;
            cmd_count    <= 4'h0;
            map_count    <= 8'h00;
            cmds_closed  <= 1'b0;
            maps_started <= 1'b0;
            maps_closing <= 1'b0;
            regions_left <= 9'h000;
            pend_addr    <= 32'h0000_0000;
            ent_ready    <= 1'b1;
            ent_ack      <= 1'b0;
            ent_err      <= 1'b0;
            err_cause    <= `SMCD_ERR_NONE;
            tbl_done     <= 1'b0;
        end
        else
        begin
            state        <= next_state;
            tbl_len      <= next_tbl_len;
            cmd_count    <= next_cmd_count;
            map_count    <= next_map_count;
            cmds_closed  <= next_cmds_closed;
            maps_started <= next_maps_started;
            maps_closing <= next_maps_closing;
            regions_left <= next_regions_left;
            pend_addr    <= next_pend_addr;
            ent_ready    <= next_ent_ready;
            ent_ack      <= next_ent_ack;
            ent_err      <= next_ent_err;
            err_cause    <= next_err_cause;
            tbl_done     <= next_tbl_done;
        end
    end

    // ------------------------------------------------------------------
    // Table storage and read path
    // ------------------------------------------------------------------
    logic rd_pend;
    logic next_rd_pend;
    logic rd_inrange;
    logic next_rd_inrange;
    logic next_rd_valid;
    logic [`SMCD_WORD_W-1:0] next_rd_data;

    smcd_table_mem u_mem
    (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .we      (mem_we),
        .waddr   (tbl_len[`SMCD_ADDR_W-1:0]),
        .wdata   (mem_wdata),
        .raddr   (rd_index),
        .rdata   (mem_rdata)
    );

    // Words beyond the built table read as erased flash
    always_comb
    begin
        next_rd_pend    = rd_req;
        next_rd_inrange = ({1'b0, rd_index} < tbl_len);
        next_rd_valid   = rd_pend;
        next_rd_data    = rd_data;
        if (rd_pend)
            next_rd_data = rd_inrange ? mem_rdata : `SMCD_UNMAPPED;
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_pend    <= 1'b0;
            rd_inrange <= 1'b0;
            rd_valid   <= 1'b0;
            rd_data    <= `SMCD_UNMAPPED;
        end
        else
        begin
            rd_pend    <= next_rd_pend;
            rd_inrange <= next_rd_inrange;
            rd_valid   <= next_rd_valid;
            rd_data    <= next_rd_data;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!resetn || tbl_clear);

    sequence s_cmd_take;
        state == SMCD_ST_OPEN && take && ent_kind == SMCD_ENT_CMD && cause == `SMCD_ERR_NONE;
    endsequence
    sequence s_addr_store;
        ##1 mem_we && state == SMCD_ST_CMD2 && !ent_ready;
    endsequence
    sequence s_rd_issue;
        rd_req;
    endsequence
    sequence s_rd_return;
        ##2 rd_valid;
    endsequence

    chk_mask_onehot: assert property (take && state == SMCD_ST_OPEN &&
        ent_kind == SMCD_ENT_CMD && !smcd_is_onehot(ent_mask) |=> ent_err && !ent_ack)
        else $error("Command with bad mask was not refused");
    chk_cmd_fields: assert property (s_cmd_take |-> mem_wdata[`SMCD_F_OPC] == ent_opcode &&
        mem_wdata[`SMCD_F_ALEN] == ent_addr_len && mem_wdata[`SMCD_F_END] == ent_last)
        else $error("Command word fields misplaced");
    chk_rsvd_ones: assert property (mem_we && state == SMCD_ST_OPEN &&
        ent_kind != SMCD_ENT_REGION |-> mem_wdata[`SMCD_F_RSVD_LO] == `SMCD_RSVD_LO)
        else $error("Reserved bits not ones");
    chk_type_bit: assert property (mem_we && state == SMCD_ST_OPEN &&
        ent_kind != SMCD_ENT_REGION |-> mem_wdata[`SMCD_F_TYPE] == (ent_kind == SMCD_ENT_HDR))
        else $error("Descriptor type bit wrong");
    chk_cmd_addr: assert property (s_cmd_take |-> s_addr_store ##0
        mem_wdata == $past(ent_addr) && tbl_len == $past(tbl_len) + 9'h001)
        else $error("Command address word not stored next");
    chk_cmd_limit: assert property (cmd_count <= `SMCD_MAX_CMDS)
        else $error("More than eight command descriptors");
    chk_region_cnt: assert property (state == SMCD_ST_OPEN && take &&
        ent_kind == SMCD_ENT_HDR && cause == `SMCD_ERR_NONE
        |=> regions_left == {1'b0, $past(ent_region_cnt)} + 9'h001)
        else $error("Region word count not count plus one");
    chk_cmd_order: assert property (maps_started |-> !(mem_we && state == SMCD_ST_OPEN &&
        ent_kind == SMCD_ENT_CMD))
        else $error("Command descriptor after a map");
    chk_read_lat: assert property (s_rd_issue |-> s_rd_return)
        else $error("Read answer not two cycles later");

endmodule

// ---- smcd_table_mem.sv ----
// Single write, single registered read memory holding the descriptor table
`timescale 1ns/1ns
`include "smcd_consts.svh"

module smcd_table_mem
(
    // Clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      resetn,
    // Write side
    input  wire logic                      we,
    input  wire logic [`SMCD_ADDR_W-1:0]   waddr,
    input  wire logic [`SMCD_WORD_W-1:0]   wdata,
    // Read side
    input  wire logic [`SMCD_ADDR_W-1:0]   raddr,
    output logic      [`SMCD_WORD_W-1:0]   rdata
);

    logic [`SMCD_WORD_W-1:0] store [0:(1<<`SMCD_ADDR_W)-1];

    // Array left without reset so it maps onto RAM
    always_ff @(posedge ref_clk)
    begin
        if (we)
        begin
            store[waddr] <= wdata;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rdata <= `SMCD_UNMAPPED;
        end
        else
        begin
            rdata <= store[raddr];
        end
    end

endmodule

// ---- testbench.sv ----
// Self-checking bench for the sector map table builder
`timescale 1ns/1ns

module testbench
    import smcd_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        resetn = 1'b0;
    logic        tbl_clear = 1'b0;
    logic        ent_valid = 1'b0;
    smcd_kind_t  ent_kind = SMCD_ENT_CMD;
    logic        ent_last = 1'b0;
    logic [7:0]  ent_mask = 8'h00, ent_opcode = 8'h00, ent_cfg_id = 8'h00, ent_region_cnt = 8'h00;
    logic [1:0]  ent_addr_len = 2'h0;
    logic [3:0]  ent_latency = 4'h0;
    logic [31:0] ent_addr = 32'h0000_0000, ent_region = 32'h0000_0000;
    logic        go = 1'b0;
    logic [7:0]  idx = 8'h00;
    logic        ent_ready, ent_ack, ent_err, tbl_done, rd_req, rd_valid, got;
    logic [2:0]  err_cause;
    logic [8:0]  tbl_len;
    logic [3:0]  cmd_count;
    logic [7:0]  map_count, rd_index;
    logic [31:0] rd_data, word;
    logic [31:0] exp_w [256];
    logic [31:0] seen_w [256];
    logic [7:0]  lsb = 8'h00, cnt0 = 8'h00;
    int          len = 0, mismatches = 0, checked = 0;

    always #25 ref_clk = ~ref_clk;

    smcd_table dut (.ref_clk(ref_clk), .resetn(resetn), .tbl_clear(tbl_clear),
        .ent_valid(ent_valid), .ent_kind(ent_kind), .ent_last(ent_last), .ent_mask(ent_mask),
        .ent_addr_len(ent_addr_len), .ent_latency(ent_latency), .ent_opcode(ent_opcode),
        .ent_addr(ent_addr), .ent_cfg_id(ent_cfg_id), .ent_region_cnt(ent_region_cnt),
        .ent_region(ent_region), .ent_ready(ent_ready), .ent_ack(ent_ack), .ent_err(ent_err),
        .err_cause(err_cause), .tbl_done(tbl_done), .tbl_len(tbl_len), .cmd_count(cmd_count),
        .map_count(map_count), .rd_req(rd_req), .rd_index(rd_index), .rd_valid(rd_valid),
        .rd_data(rd_data));

    smcd_host_model host (.ref_clk(ref_clk), .resetn(resetn), .go(go), .idx(idx),
        .word(word), .got(got), .rd_req(rd_req), .rd_index(rd_index), .rd_valid(rd_valid),
        .rd_data(rd_data));

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e)
        begin
            mismatches++;
            $display("ERROR %0t seen %h expected %h", $time, s, e);
        end
    endtask

    task automatic give_verdict();
        if (mismatches == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    function automatic void push(input logic [31:0] w);
        exp_w[len] = w;
        len++;
    endfunction

    // Host walk over the fetched image: last command sees lsb_byte, others a miss
    function automatic logic [7:0] selector(input logic [7:0] lsb_byte);
        logic [7:0] s;
        logic [7:0] rx;
        s = 8'h00;
        for (int i = 0; i < len && seen_w[i][1] == 1'b0; i += 2)
        begin
            rx = seen_w[i][0] ? lsb_byte : ~seen_w[i][31:24];
            s = {s[6:0], |(seen_w[i][31:24] & rx)};
        end
        return s;
    endfunction

    function automatic int find_map(input logic [7:0] sel);
        int i;
        i = 0;
        while (i < len && seen_w[i][1] == 1'b0)
            i += 2;
        while (i < len)
        begin
            if (seen_w[i][15:8] == sel)
                return i;
            if (seen_w[i][0])
                break;
            i = i + int'(seen_w[i][23:16]) + 2;
        end
        return -1;
    endfunction

    // Offer one entry and expect acceptance (cause 0) or refusal with cause c
    task automatic offer(input logic [2:0] c);
        int n;
        n = 0;
        while (ent_ready !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk);
            #2;
            n++;
        end
        ent_valid = 1'b1;
        @(posedge ref_clk);
        #2;
        ent_valid = 1'b0;
        // Answer stands only in the cycle after the take
        check(ent_ack, c == 3'h0);
        check(ent_err, c != 3'h0);
        check(err_cause, c);
        @(posedge ref_clk);
        #2;
    endtask

    task automatic map(input logic [7:0] id, input logic [7:0] cnt, input logic last);
        ent_kind = SMCD_ENT_HDR;
        ent_cfg_id = id;
        ent_region_cnt = cnt;
        ent_last = last;
        offer(3'h0);
        push({8'hFF, cnt, id, 6'h3F, 1'b1, last});
        ent_kind = SMCD_ENT_REGION;
        for (int r = 0; r <= cnt; r++)
        begin
            ent_region = $urandom;
            offer(3'h0);
            push(ent_region);
        end
    endtask

    task automatic fetch(input int i);
        int n;
        go = 1'b1;
        idx = 8'(i);
        @(posedge ref_clk);
        #2;
        go = 1'b0;
        n = 0;
        while (got !== 1'b1 && n < 8)
        begin
            @(posedge ref_clk);
            #2;
            n++;
        end
    endtask

    task automatic readback();
        check(tbl_len, len);
        for (int i = 0; i < len; i++)
        begin
            fetch(i);
            seen_w[i] = word;
            check(word, exp_w[i]);
        end
        fetch(len);
        check(word, 32'hFFFF_FFFF);
    endtask

    // ----------------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------------
    initial
    begin
        repeat (5000) @(posedge ref_clk);
        mismatches++;
        give_verdict();
    end

    initial
    begin
        void'($urandom(32'had36_3225));
        repeat (10) @(posedge ref_clk);
        #2;
        resetn = 1'b1;
        check(ent_ready, 1'b1);
        ent_kind = SMCD_ENT_REGION;
        offer(3'h5);
        ent_kind = SMCD_ENT_CMD;
        ent_mask = 8'h00;
        offer(3'h1);
        ent_mask = 8'h81;
        offer(3'h1);
        check(tbl_len, 9'h000);
        for (int i = 0; i < 4; i++)
        begin
            ent_mask = 8'h01 << ($urandom % 8);
            ent_addr_len = i[1:0];
            ent_latency = (i == 3) ? 4'hF : 4'($urandom % 15);
            ent_opcode = 8'($urandom);
            ent_addr = $urandom;
            ent_last = (i == 3);
            offer(3'h0);
            push({ent_mask, ent_addr_len, 2'b11, ent_latency, ent_opcode, 6'h3F, 1'b0, ent_last});
            push(ent_addr);
        end
        check(cmd_count, 4'h4);
        offer(3'h2);
        cnt0 = 8'($urandom % 3);
        map(8'h00, cnt0, 1'b0);
        map(8'h01, 8'h00, 1'b1);
        check(tbl_done, 1'b1);
        check(map_count, 8'h02);
        ent_kind = SMCD_ENT_REGION;
        offer(3'h6);
        readback();
        lsb = ($urandom & 1) ? 8'hFF : 8'h00;
        check(selector(lsb), {24'h00_0000, 7'h00, lsb[0]});
        check(find_map(selector(lsb)), lsb[0] ? 32'h0000_000A + 32'(cnt0) : 32'h0000_0008);
        check(find_map(8'h02), 32'hFFFF_FFFF);
        tbl_clear = 1'b1;
        @(posedge ref_clk);
        #2;
        tbl_clear = 1'b0;
        len = 0;
        map(8'h00, 8'h01, 1'b1);
        check(cmd_count, 4'h0);
        readback();
        check(selector(8'hFF), 32'h0000_0000);
        check(find_map(8'h00), 32'h0000_0000);
        // Full command run: eighth without end marker is refused, then room runs out
        tbl_clear = 1'b1;
        @(posedge ref_clk);
        #2;
        tbl_clear = 1'b0;
        ent_kind = SMCD_ENT_CMD;
        for (int i = 0; i < 9; i++)
        begin
            ent_last = (i == 8);
            offer((i == 7) ? 3'h3 : 3'h0);
        end
        check(cmd_count, 4'h8);
        ent_kind = SMCD_ENT_HDR;
        ent_region_cnt = 8'hFF;
        offer(3'h4);
        give_verdict();
    end
endmodule
